// >>> shared/sci_pkg.sv
// constants, types and field layout of the serial controller interrupt block
// assumes one clock and a plain strobe-based register port
//
// Overview of operation
// - registers are reached over the strobe port at fixed word addresses
// - poll register shows data-move bits; pending register holds both channels
// - six sources each own pending, in-service and enable flags
// - requests need the source enable and the global enable; source enables are write-only
// - a pending flag never sets while its enable is clear
// - any eligible pending flag with chain input high pulls the request low
// - pending flags are readable in the pending-bits register
// - a set in-service flag blocks lower sources and drops chain output
// - acknowledge sets in-service of highest pending source if chain input high
// - channel A above B; receive, transmit, external/status within a channel
// - acknowledge releases the request output so higher sources may nest
// - three vector bits carry source; channel A read plain, channel B with status
// - receive interrupt modes: first char, every char, special only
// - special condition: overrun, framing, end of frame, optional parity
// - first-char mode raises special conditions only after the first char
// - ext/status from pin edges, underrun, baud zero, break or abort
// - break or abort interrupts at start and at end
// - software acknowledge by vector read when enabled in master control
// - software acknowledge ignores status-in-vector and suppress-vector bits
// - transfer mode bits make wait/request a cpu wait or dma request
// - request means ready to move data; wait means not ready, stretch cycle
// - chain output high only if input high, not servicing, not requesting in ack
// - acknowledge sampled on clock edge; vector on read with chain input high
package sci_pkg;
  // ****************************************
  // register port
  // ****************************************
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADR_MIC = 4'h0;
  localparam logic [3:0] ADR_VEC_WR = 4'h1;
  localparam logic [3:0] ADR_VEC_A = 4'h2;
  localparam logic [3:0] ADR_VEC_B = 4'h3;
  localparam logic [3:0] ADR_PEND = 4'h4;
  localparam logic [3:0] ADR_TM_A = 4'h5;
  localparam logic [3:0] ADR_TM_B = 4'h6;
  localparam logic [3:0] ADR_CMD = 4'h7;
  localparam logic [3:0] ADR_POLL = 4'h8;
  // ****************************************
  // field positions
  // ****************************************
  localparam int MIC_VIS = 0;
  localparam int MIC_NV = 1;
  localparam int MIC_MIE = 3;
  localparam int MIC_SACK = 5;
  localparam int TM_RXM_LO = 0;
  localparam int TM_TX_EN = 2;
  localparam int TM_EXT_EN = 3;
  localparam int TM_WR_EN = 4;
  localparam int TM_WR_REQ = 5;
  localparam int TM_WR_RX = 6;
  localparam int TM_PAR_SP = 7;
  localparam int CMD_RST_IUS = 0;
  localparam int CMD_CLR_LO = 1;
  localparam int CMD_ARM = 7;
  localparam int VEC_LO = 1;
  // ****************************************
  // sources, reset values, codes
  // ****************************************
  localparam int NCH = 2;
  localparam int SRC_PER_CH = 3;
  localparam int NSRC = 6;
  localparam int SRC_RX = 0;
  localparam int SRC_TX = 1;
  localparam int SRC_EXT = 2;
  localparam logic [7:0] MIC_RST = 8'h00;
  localparam logic [7:0] VEC_RST = 8'h00;
  localparam logic [7:0] TM_RST = 8'h00;
  localparam logic [2:0] VEC_NONE = 3'h3;
  localparam logic [2:0] VEC_SPECIAL = 3'h3;
  localparam logic [2:0] VEC_RX = 3'h2;
  localparam logic [2:0] VEC_TX = 3'h0;
  localparam logic [2:0] VEC_EXT = 3'h1;
  localparam logic [2:0] VEC_CH_A = 3'h4;
  typedef enum logic [1:0] {
    RXM_OFF = 2'h0,
    RXM_FIRST = 2'h1,
    RXM_ALL = 2'h2,
    RXM_SPECIAL = 2'h3
  } sci_rxm_t;
  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_SETTLE = 2'b01,
    ACK_DONE = 2'b11
  } sci_ack_t;
endpackage : sci_pkg

// >>> src/sci_chain.sv
// internal daisy chain: highest eligible pending source and highest in-service
// assumes index 0 is the highest priority
`timescale 1ns/10ps
module sci_chain #(
  parameter int N = 6
) (
  // flags
  input wire logic [N-1:0] pend,
  input wire logic [N-1:0] in_service_flag,
  // results
  output logic [N-1:0] grant,
  output logic [N-1:0] hi_ius,
  output logic any_req
);
  logic [N:0] blk;
  logic [N:0] found;
  assign blk[0] = 1'b0;
  assign found[0] = 1'b0;
  // ****************************************
  // priority walk
  // ****************************************
  for (genvar i = 0; i < N; i++) begin : g_lvl
    // a source is blocked by in-service at its own level or above
    assign grant[i] = pend[i] & ~blk[i] & ~in_service_flag[i] & ~found[i];
    assign hi_ius[i] = in_service_flag[i] & ~blk[i];
    assign blk[i+1] = blk[i] | in_service_flag[i];
    assign found[i+1] = found[i] | grant[i];
  end
  assign any_req = found[N];
endmodule : sci_chain

// >>> src/sci_irq_xfer.sv
// interrupt, daisy chain, vector and wait/request logic of a two-channel controller
// assumes status inputs synchronous to clk, channel 0 is A and channel 1 is B
`timescale 1ns/10ps
module sci_irq_xfer
  import sci_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // daisy chain and request pin
  input wire logic irq_acknowledge_n,
  input wire logic chain_enable_in,
  output logic chain_enable_out,
  output logic irq_req_o,
  output logic irq_req_oe,
  // channel status
  input wire logic [NCH-1:0] rx_avail,
  input wire logic [NCH-1:0] tx_empty,
  input wire logic [NCH-1:0] rx_overrun,
  input wire logic [NCH-1:0] rx_framing_err,
  input wire logic [NCH-1:0] rx_end_of_frame,
  input wire logic [NCH-1:0] rx_parity_err,
  input wire logic [NCH-1:0] cts_in,
  input wire logic [NCH-1:0] carrier_detect_in,
  input wire logic [NCH-1:0] sync_in,
  input wire logic [NCH-1:0] break_abort_in,
  input wire logic [NCH-1:0] tx_underrun,
  input wire logic [NCH-1:0] brg_zero,
  input wire logic [NCH-1:0] data_access,
  // wait/request pins
  output logic [NCH-1:0] wait_req_o,
  output logic [NCH-1:0] wait_req_oe
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ****************************************
  // state
  // ****************************************
  logic [7:0] mic_ff, nxt_mic;
  logic [7:0] vec_ff, nxt_vec;
  logic [NCH-1:0][7:0] tm_ff, nxt_tm;
  logic [NSRC-1:0] pend_ff, nxt_pend;
  logic [NSRC-1:0] ius_ff, nxt_ius;
  logic [NCH-1:0] special_ff, nxt_special;
  logic [NCH-1:0] armed_ff, nxt_armed;
  logic [NCH-1:0][5:0] prev_ff, nxt_prev;
  sci_ack_t ack_st_ff, nxt_ack_st;
  logic [7:0] rdata_ff, nxt_rdata;
  logic int_oe_ff, nxt_int_oe;
  logic chain_out_ff, nxt_chain_out;
  logic [NCH-1:0] wr_o_ff, nxt_wr_o;
  logic [NCH-1:0] wr_oe_ff, nxt_wr_oe;

  // ****************************************
  // per-channel events
  // ****************************************
  logic [NSRC-1:0] src_set;
  logic [NSRC-1:0] src_en;
  logic [NCH-1:0] sp_set;
  logic [NCH-1:0] fc_take;
  logic [NCH-1:0] ready;
  logic [NCH-1:0][5:0] lvl;
  logic [NSRC-1:0] pend_view;
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    sci_rxm_t rxm;
    logic rx_rise;
    logic tx_rise;
    logic sp;
    logic char_set;
    assign rxm = sci_rxm_t'(tm_ff[c][TM_RXM_LO +: 2]);
    assign lvl[c] = {break_abort_in[c], sync_in[c], carrier_detect_in[c],
                     cts_in[c], tx_empty[c], rx_avail[c]};
    assign rx_rise = rx_avail[c] & ~prev_ff[c][0];
    assign tx_rise = tx_empty[c] & ~prev_ff[c][1];
    assign sp = rx_overrun[c] | rx_framing_err[c] | rx_end_of_frame[c]
              | (rx_parity_err[c] & tm_ff[c][TM_PAR_SP]);
    assign fc_take[c] = (rxm == RXM_FIRST) & rx_rise & armed_ff[c];
    assign char_set = (rxm == RXM_ALL & rx_rise) | fc_take[c];
    // first-char mode takes special conditions only once disarmed
    assign sp_set[c] = sp & (rxm == RXM_ALL | rxm == RXM_SPECIAL
                     | (rxm == RXM_FIRST & ~armed_ff[c]));
    assign src_en[c*SRC_PER_CH+SRC_RX] = rxm != RXM_OFF;
    assign src_en[c*SRC_PER_CH+SRC_TX] = tm_ff[c][TM_TX_EN];
    assign src_en[c*SRC_PER_CH+SRC_EXT] = tm_ff[c][TM_EXT_EN];
    assign src_set[c*SRC_PER_CH+SRC_RX] = char_set | sp_set[c];
    assign src_set[c*SRC_PER_CH+SRC_TX] = tx_rise;
    // both edges of the cts, carrier, sync and break/abort levels
    assign src_set[c*SRC_PER_CH+SRC_EXT] = (|(lvl[c][5:2] ^ prev_ff[c][5:2]))
                                         | tx_underrun[c] | brg_zero[c];
    assign ready[c] = tm_ff[c][TM_WR_RX] ? rx_avail[c] : tx_empty[c];
  end
  // highest source shows in the top bit of the pending view
  for (genvar i = 0; i < NSRC; i++) begin : g_view
    assign pend_view[NSRC-1-i] = pend_ff[i];
  end

  // ****************************************
  // daisy chain
  // ****************************************
  logic [NSRC-1:0] grant;
  logic [NSRC-1:0] hi_ius;
  logic any_req;
  sci_chain #(
    .N(NSRC)
  ) u_chain (
    .pend(pend_ff),
    .in_service_flag(ius_ff),
    .grant(grant),
    .hi_ius(hi_ius),
    .any_req(any_req)
  );

  // ****************************************
  // decode and vector
  // ****************************************
  logic wr_mic, wr_cmd, hw_take, sw_take, take, sack;
  logic [2:0] code;
  logic [7:0] vec_mod;
  assign sack = mic_ff[MIC_SACK];
  assign wr_mic = reg_wr & (reg_addr == ADR_MIC);
  assign wr_cmd = reg_wr & (reg_addr == ADR_CMD);
  assign hw_take = (ack_st_ff == ACK_SETTLE) & reg_rd & chain_enable_in;
  assign sw_take = sack & reg_rd & irq_acknowledge_n
                 & (reg_addr == ADR_VEC_A | reg_addr == ADR_VEC_B);
  assign take = hw_take | sw_take;

  always_comb begin
    code = VEC_NONE;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (grant[c*SRC_PER_CH+SRC_EXT]) begin
        code = VEC_EXT;
      end
      if (grant[c*SRC_PER_CH+SRC_TX]) begin
        code = VEC_TX;
      end
      if (grant[c*SRC_PER_CH+SRC_RX]) begin
        code = special_ff[c] ? VEC_SPECIAL : VEC_RX;
      end
      if (c == 0 && |grant[SRC_PER_CH-1:0]) begin
        code = code | VEC_CH_A;
      end
    end
    vec_mod = vec_ff;
    vec_mod[VEC_LO +: 3] = code;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_mic = wr_mic ? reg_wdata : mic_ff;
    nxt_vec = (reg_wr & reg_addr == ADR_VEC_WR) ? reg_wdata : vec_ff;
    nxt_tm = tm_ff;
    if (reg_wr & reg_addr == ADR_TM_A) begin
      nxt_tm[0] = reg_wdata;
    end
    if (reg_wr & reg_addr == ADR_TM_B) begin
      nxt_tm[1] = reg_wdata;
    end
    // set wins over clear; disabled sources drop their flag
    nxt_pend = ((pend_ff & ~(wr_cmd ? reg_wdata[CMD_CLR_LO +: NSRC] : '0))
               | src_set) & src_en;
    // in-service set by acknowledge wins over reset of highest
    nxt_ius = (ius_ff & ~((wr_cmd & reg_wdata[CMD_RST_IUS]) ? hi_ius : '0))
            | (take ? grant : '0);
    for (int c = 0; c < NCH; c++) begin
      nxt_special[c] = (special_ff[c] | sp_set[c]) & nxt_pend[c*SRC_PER_CH+SRC_RX];
      nxt_armed[c] = (armed_ff[c] & ~fc_take[c]) | (wr_cmd & reg_wdata[CMD_ARM]);
    end
    nxt_prev = lvl;
    // hardware acknowledge follows the sampled pin
    unique case (ack_st_ff)
      ACK_IDLE: nxt_ack_st = irq_acknowledge_n ? ACK_IDLE : ACK_SETTLE;
      ACK_SETTLE: begin
        nxt_ack_st = irq_acknowledge_n ? ACK_IDLE : (reg_rd ? ACK_DONE : ACK_SETTLE);
      end
      ACK_DONE: nxt_ack_st = irq_acknowledge_n ? ACK_IDLE : ACK_DONE;
      default: nxt_ack_st = ACK_IDLE;
    endcase
    nxt_rdata = 8'h00;
    if (reg_rd && ack_st_ff == ACK_SETTLE) begin
      if (chain_enable_in && !mic_ff[MIC_NV]) begin
        nxt_rdata = mic_ff[MIC_VIS] ? vec_mod : vec_ff;
      end
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADR_VEC_A: nxt_rdata = vec_ff;
        ADR_VEC_B: nxt_rdata = vec_mod;
        ADR_PEND: nxt_rdata = {2'b00, pend_view};
        ADR_MIC: nxt_rdata = mic_ff;
        ADR_POLL: nxt_rdata = {4'h0, tx_empty[1], rx_avail[1], tx_empty[0], rx_avail[0]};
        default: nxt_rdata = 8'h00;
      endcase
    end
    nxt_int_oe = mic_ff[MIC_MIE] & chain_enable_in & any_req & irq_acknowledge_n
               & (ack_st_ff == ACK_IDLE) & ~take;
    nxt_chain_out = chain_enable_in & ~|nxt_ius
                  & ~(~irq_acknowledge_n & any_req & mic_ff[MIC_MIE]);
    for (int c = 0; c < NCH; c++) begin
      nxt_wr_o[c] = 1'b1;
      nxt_wr_oe[c] = 1'b0;
      if (tm_ff[c][TM_WR_EN] && tm_ff[c][TM_WR_REQ]) begin
        nxt_wr_o[c] = ~ready[c];
        nxt_wr_oe[c] = 1'b1;
      end else if (tm_ff[c][TM_WR_EN]) begin
        nxt_wr_o[c] = 1'b0;
        nxt_wr_oe[c] = data_access[c] & ~ready[c];
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      mic_ff <= MIC_RST;
      vec_ff <= VEC_RST;
      tm_ff <= {NCH{TM_RST}};
      pend_ff <= '0;
      ius_ff <= '0;
      special_ff <= '0;
      armed_ff <= '1;
      prev_ff <= '0;
      ack_st_ff <= ACK_IDLE;
      rdata_ff <= 8'h00;
      int_oe_ff <= 1'b0;
      chain_out_ff <= 1'b0;
      wr_o_ff <= '1;
      wr_oe_ff <= '0;
    end else begin
      mic_ff <= nxt_mic;
      vec_ff <= nxt_vec;
      tm_ff <= nxt_tm;
      pend_ff <= nxt_pend;
      ius_ff <= nxt_ius;
      special_ff <= nxt_special;
      armed_ff <= nxt_armed;
      prev_ff <= nxt_prev;
      ack_st_ff <= nxt_ack_st;
      rdata_ff <= nxt_rdata;
      int_oe_ff <= nxt_int_oe;
      chain_out_ff <= nxt_chain_out;
      wr_o_ff <= nxt_wr_o;
      wr_oe_ff <= nxt_wr_oe;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic int_o_ff;
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      int_o_ff <= 1'b1;
    end else begin
      int_o_ff <= ~nxt_int_oe;
    end
  end
  assign reg_rdata = rdata_ff;
  assign irq_req_o = int_o_ff;
  assign irq_req_oe = int_oe_ff;
  assign chain_enable_out = chain_out_ff;
  assign wait_req_o = wr_o_ff;
  assign wait_req_oe = wr_oe_ff;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_ff);

  a_pend_gate: assert property ((pend_ff & ~$past(src_en)) == '0)
    else $error("pending flag set while its enable was clear");
  a_mie_off: assert property (!mic_ff[MIC_MIE] |=> !int_oe_ff)
    else $error("request driven with global enable clear");
  a_int_request: assert property ((|pend_ff && ~|ius_ff && mic_ff[MIC_MIE]
      && chain_enable_in && irq_acknowledge_n && ack_st_ff == ACK_IDLE && !reg_rd)
      |=> int_oe_ff && !irq_req_o)
    else $error("pending source did not pull the request low");
  a_ack_release: assert property (!irq_acknowledge_n |=> !int_oe_ff [*2])
    else $error("request not released during acknowledge");
  a_ius_block: assert property ((|ius_ff && !wr_cmd) |=> !chain_out_ff)
    else $error("chain output high while in service");
  a_chain_in_low: assert property (!chain_enable_in |=> !chain_out_ff && !int_oe_ff)
    else $error("chain output or request with chain input low");
  a_hw_ack_ius: assert property ((hw_take && |grant)
      |=> (ius_ff & $past(grant)) == $past(grant))
    else $error("acknowledge did not set in-service");
  a_sw_ack: assert property ((sw_take && |grant) |=> !int_oe_ff && !chain_out_ff)
    else $error("software acknowledge left request or chain active");
  a_pend_read: assert property ((reg_rd && reg_addr == ADR_PEND && ack_st_ff != ACK_SETTLE)
      |=> reg_rdata[NSRC-1:0] == $past(pend_view))
    else $error("pending register read mismatch");
  a_vec_plain: assert property ((reg_rd && reg_addr == ADR_VEC_A && ack_st_ff != ACK_SETTLE)
      |=> reg_rdata == $past(vec_ff))
    else $error("channel A vector carried status");
  a_rst_highest: assert property ((wr_cmd && reg_wdata[CMD_RST_IUS] && !take)
      |=> ius_ff == ($past(ius_ff) & ~$past(hi_ius)))
    else $error("reset highest cleared the wrong in-service flag");
  a_req_mode: assert property ((tm_ff[0][TM_WR_EN] && tm_ff[0][TM_WR_REQ])
      |=> wait_req_oe[0] && wait_req_o[0] == !$past(ready[0]))
    else $error("request mode output wrong");
  a_wait_mode: assert property ((tm_ff[0][TM_WR_EN] && !tm_ff[0][TM_WR_REQ]
      && data_access[0] && !ready[0]) |=> wait_req_oe[0] && !wait_req_o[0])
    else $error("wait not asserted when not ready");
endmodule : sci_irq_xfer

// >>> dv/sci_host_model.sv
// far side of the block: host cpu acknowledge and the pulled-up request pins
// assumes the bench asks for an acknowledge cycle by holding ack_go high
`timescale 1ns/10ps
module sci_host_model
  import sci_pkg::*;
(
  // clock and bench control
  input wire logic clk,
  input wire logic ack_go,
  // request pin and acknowledge
  input wire logic irq_req_o,
  input wire logic irq_req_oe,
  output logic irq_acknowledge_n,
  output logic irq_line,
  // wait/request pins
  input wire logic [NCH-1:0] wait_req_o,
  input wire logic [NCH-1:0] wait_req_oe,
  output logic [NCH-1:0] wait_line
);
  // ****************************************
  // acknowledge and pin levels
  // ****************************************
  initial irq_acknowledge_n = 1'b1;
  // acknowledge is a level changed just after the edge
  always @(posedge clk) irq_acknowledge_n <= ~ack_go;
  // a released open-drain pin floats to the pull-up level
  assign irq_line = irq_req_oe ? irq_req_o : 1'b1;
  assign wait_line = (wait_req_oe & wait_req_o) | ~wait_req_oe;
endmodule : sci_host_model

// >>> dv/sci_irq_xfer_tb_top.sv
// self-checking bench of the interrupt and wait/request block
// assumes the host model resolves the pins and drives the acknowledge
`timescale 1ns/10ps
module sci_irq_xfer_tb_top
  import sci_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic clk, rst_n, reg_wr, reg_rd, chain_in, chain_out, irq_o, irq_oe, ack_n, ack_go;
  logic irq_line;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [NCH-1:0] rx_avail, tx_empty, rx_ovr, cts, dcd, syn, brk, und, brg, dacc;
  logic [NCH-1:0] rx_fe, rx_eof, rx_par;
  logic [NCH-1:0] wait_o, wait_oe, wait_line;
  int err_count, tests_run;
  int kt[7] = '{0, 1, 2, 3, 3, 4, 5};
  sci_irq_xfer sci_irq_xfer_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_acknowledge_n(ack_n), .chain_enable_in(chain_in), .chain_enable_out(chain_out),
    .irq_req_o(irq_o), .irq_req_oe(irq_oe), .rx_avail(rx_avail), .tx_empty(tx_empty),
    .rx_overrun(rx_ovr), .rx_framing_err(rx_fe), .rx_end_of_frame(rx_eof),
    .rx_parity_err(rx_par), .cts_in(cts), .carrier_detect_in(dcd), .sync_in(syn),
    .break_abort_in(brk), .tx_underrun(und), .brg_zero(brg), .data_access(dacc),
    .wait_req_o(wait_o), .wait_req_oe(wait_oe));
  sci_host_model sci_host_model_i (.clk(clk), .ack_go(ack_go), .irq_req_o(irq_o),
    .irq_req_oe(irq_oe), .irq_acknowledge_n(ack_n), .irq_line(irq_line),
    .wait_req_o(wait_o), .wait_req_oe(wait_oe), .wait_line(wait_line));
  // ****************************************
  // tasks
  // ****************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask : rchk
  task automatic ev(input int k);
    @(posedge clk);
    case (k)
      0: cts[0] <= ~cts[0];
      1: dcd[0] <= ~dcd[0];
      2: syn[0] <= ~syn[0];
      3: brk[0] <= ~brk[0];
      4: und[0] <= 1'b1;
      default: brg[0] <= 1'b1;
    endcase
    @(posedge clk);
    und <= '0;
    brg <= '0;
  endtask : ev
  // ****************************************
  // clock, watchdog, sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end
  initial begin
    err_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, ack_go} = '0;
    {rx_avail, tx_empty, rx_ovr, rx_fe, rx_eof, rx_par} = '0;
    {cts, dcd, syn, brk, und, brg, dacc} = '0;
    chain_in = 1'b1;
    cyc(10);
    chk("chain_out_rst", 8'h00, {7'h00, chain_out});
    chk("irq_rst", 8'h01, {7'h00, irq_line});
    @(posedge clk) rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr(ADR_MIC, 8'h08);
    rchk(ADR_MIC, 8'h08, "mic");
    wr(ADR_TM_A, 8'h0C);
    rchk(ADR_TM_A, 8'h00, "tm_write_only");
    wr(4'hF, 8'hFF);
    rchk(4'hF, 8'h00, "unmapped");
    rchk(ADR_MIC, 8'h08, "mic_kept");
    wr(ADR_TM_A, 8'h00);
    @(posedge clk) {rx_avail, tx_empty} <= 4'b0101;
    cyc(2);
    rchk(ADR_POLL, 8'h03, "poll");
    @(posedge clk) {rx_avail, tx_empty} <= 4'b0000;
    $display("test registers done");
    wr(ADR_MIC, 8'h00);
    @(posedge clk) tx_empty <= 2'b01;
    cyc(2);
    rchk(ADR_PEND, 8'h00, "pend_disabled");
    @(posedge clk) tx_empty <= 2'b00;
    wr(ADR_TM_A, 8'h04);
    @(posedge clk) tx_empty <= 2'b01;
    cyc(2);
    rchk(ADR_PEND, 8'h10, "pend_tx_a");
    chk("irq_no_mie", 8'h01, {7'h00, irq_line});
    wr(ADR_MIC, 8'h08);
    cyc(2);
    chk("irq_req", 8'h00, {7'h00, irq_line});
    @(posedge clk) chain_in <= 1'b0;
    cyc(2);
    chk("irq_chain_low", 8'h01, {7'h00, irq_line});
    @(posedge clk) chain_in <= 1'b1;
    $display("test enables done");
    wr(ADR_VEC_WR, 8'hF1);
    wr(ADR_TM_B, 8'h08);
    @(posedge clk) brg <= 2'b10;
    @(posedge clk) brg <= 2'b00;
    cyc(2);
    rchk(ADR_PEND, 8'h11, "pend_two");
    rchk(ADR_VEC_A, 8'hF1, "vec_a_plain");
    wr(ADR_MIC, 8'h2B);
    rchk(ADR_VEC_B, 8'hF9, "vec_b_tx_a");
    cyc(1);
    chk("chain_out_ius", 8'h00, {7'h00, chain_out});
    chk("irq_released", 8'h01, {7'h00, irq_line});
    wr(ADR_CMD, 8'h05);
    cyc(2);
    chk("chain_out_back", 8'h01, {7'h00, chain_out});
    chk("irq_ext_b", 8'h00, {7'h00, irq_line});
    rchk(ADR_VEC_B, 8'hF3, "vec_b_ext_b");
    wr(ADR_CMD, 8'h41);
    rchk(ADR_PEND, 8'h00, "pend_cleared");
    wr(ADR_TM_B, 8'h00);
    $display("test software acknowledge done");
    wr(ADR_MIC, 8'h08);
    @(posedge clk) tx_empty <= 2'b00;
    @(posedge clk) tx_empty <= 2'b01;
    @(posedge clk) {chain_in, ack_go} <= 2'b01;
    cyc(3);
    rchk(ADR_VEC_A, 8'h00, "ack_chain_low");
    chk("chain_out_in_low", 8'h00, {7'h00, chain_out});
    @(posedge clk) {chain_in, ack_go} <= 2'b10;
    cyc(3);
    chk("chain_out_no_ius", 8'h01, {7'h00, chain_out});
    @(posedge clk) ack_go <= 1'b1;
    cyc(3);
    chk("irq_hw_ack", 8'h01, {7'h00, irq_line});
    chk("chain_out_ack", 8'h00, {7'h00, chain_out});
    rchk(ADR_VEC_A, 8'hF1, "vec_hw_ack");
    cyc(1);
    chk("chain_out_hw_ius", 8'h00, {7'h00, chain_out});
    @(posedge clk) ack_go <= 1'b0;
    wr(ADR_CMD, 8'h05);
    cyc(2);
    chk("chain_out_hw_done", 8'h01, {7'h00, chain_out});
    wr(ADR_TM_A, 8'h00);
    $display("test hardware acknowledge done");
    for (int i = 0; i < 4; i++) begin
      logic [1:0] m;
      m = 2'((i == 3) ? 1 : i + 1 - (i == 0));
      wr(ADR_TM_A, {6'h00, m});
      @(posedge clk) rx_avail <= 2'b01;
      cyc(2);
      rchk(ADR_PEND, (m == 2'd1 || m == 2'd2) ? 8'h20 : 8'h00, "rx_mode");
      if (m != 2'd1) begin
        @(posedge clk) rx_avail <= 2'b00;
        wr(ADR_TM_A, 8'h00);
      end
    end
    wr(ADR_MIC, 8'h28);
    rchk(ADR_VEC_B, 8'hFD, "vec_rx_a");
    wr(ADR_CMD, 8'h03);
    @(posedge clk) rx_avail <= 2'b00;
    @(posedge clk) rx_avail <= 2'b01;
    cyc(2);
    rchk(ADR_PEND, 8'h00, "rx_second_char");
    wr(ADR_TM_A, 8'h81);
    // overrun, framing, end of frame, parity; then overrun while re-armed
    for (int j = 0; j < 5; j++) begin
      if (j == 4) begin
        wr(ADR_CMD, 8'h80);
      end
      @(posedge clk) {rx_par, rx_eof, rx_fe, rx_ovr} <= 8'h01 << (2 * (j % 4));
      @(posedge clk) {rx_par, rx_eof, rx_fe, rx_ovr} <= 8'h00;
      cyc(2);
      rchk(ADR_PEND, (j < 4) ? 8'h20 : 8'h00, "rx_special");
      if (j < 4) begin
        rchk(ADR_VEC_B, 8'hFF, "vec_special");
        wr(ADR_CMD, 8'h03);
      end
    end
    wr(ADR_TM_A, 8'h00);
    $display("test receive modes done");
    wr(ADR_MIC, 8'h08);
    wr(ADR_TM_A, 8'h08);
    for (int i = 0; i < 7; i++) begin
      ev(kt[i]);
      cyc(2);
      rchk(ADR_PEND, 8'h08, "ext_cause");
      wr(ADR_CMD, 8'h08);
    end
    wr(ADR_TM_A, 8'h00);
    $display("test external status done");
    wr(ADR_TM_A, 8'h70);
    @(posedge clk) rx_avail <= 2'b00;
    cyc(2);
    chk("req_idle", 8'h01, {7'h00, wait_line[0]});
    @(posedge clk) rx_avail <= 2'b01;
    cyc(2);
    chk("req_ready", 8'h00, {7'h00, wait_line[0]});
    wr(ADR_TM_A, 8'h10);
    @(posedge clk) {tx_empty, dacc} <= 4'b0001;
    cyc(2);
    chk("wait_oe", 8'h01, {7'h00, wait_oe[0]});
    chk("wait_low", 8'h00, {7'h00, wait_line[0]});
    @(posedge clk) tx_empty <= 2'b01;
    cyc(2);
    chk("wait_ready", 8'h00, {7'h00, wait_oe[0]});
    wr(ADR_TM_A, 8'h00);
    cyc(2);
    chk("wait_off", 8'h00, {7'h00, wait_oe[0]});
    wr(ADR_TM_B, 8'h30);
    cyc(2);
    chk("req_b_oe", 8'h01, {7'h00, wait_oe[1]});
    chk("req_b_idle", 8'h01, {7'h00, wait_line[1]});
    $display("test wait request done");
    stop_test();
  end
endmodule : sci_irq_xfer_tb_top
